// ===== core/sci_rx_pkg.sv
// Purpose: shared constants and types of the asynchronous serial receiver
// Assumes: one master clock, oversampling rate set by a 12-bit prescaler
// Notes:   input register offsets are byte addresses of the core's input space
package ser_rx_pkg;

   typedef logic [1:0]  fmt_t;
   typedef logic [11:0] presc_t;

   // input register map
   localparam logic [7:0] ADDR_DATA_IN = 8'h24;
   localparam logic [7:0] ADDR_STATUS  = 8'h35;

   // status field positions
   localparam int ST_NOISE   = 7;
   localparam int ST_FRAME   = 6;
   localparam int ST_FULL    = 5;
   localparam int ST_OVERRUN = 4;
   localparam int ST_NINTH   = 2;

   localparam logic [7:0] DATA_RESET   = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // frame format select codes
   localparam fmt_t FMT_8N1    = 2'h0;
   localparam fmt_t FMT_8N2    = 2'h1;
   localparam fmt_t FMT_8P1    = 2'h2;
   localparam fmt_t FMT_9N1    = 2'h3;

   // oversampling: sixteen sample states per bit, states 1..16 held as 0..15
   localparam int          OVERSAMPLE = 16;
   localparam logic [3:0]  SAMP_A     = 4'h7;
   localparam logic [3:0]  SAMP_B     = 4'h8;
   localparam logic [3:0]  SAMP_C     = 4'h9;

   // acquisition steps per character, counted from zero
   localparam logic [3:0]  STEP_LAST_SHORT = 4'h8;
   localparam logic [3:0]  STEP_LAST_LONG  = 4'h9;
   localparam logic [3:0]  STEP_EXTRA      = 4'h8;
   localparam logic [3:0]  BREAK_BITS      = 4'ha;

endpackage

// ===== core/rx_link_if.sv
// Purpose: carries the oversampling tick and the cleaned receive level
// Assumes: both ends run on the master clock
// Notes:   tick is a one-cycle enable at sixteen times the bit rate
`timescale 1ns/10ps
interface rx_link_if;
   logic tick;
   logic line;
   modport front (output tick, output line);
   modport core  (input tick, input line);
endinterface

// ===== core/rx_front.sv
// Purpose: receive pin synchroniser and oversampling rate divider
// Assumes: prescaler value is static while reception is enabled
// Notes:   prescaler 0 behaves as 1, giving a tick every clock
`timescale 1ns/10ps
module rx_front
   import ser_rx_pkg::*;
(
   input  wire logic               clock_i,
   input  wire logic               rst_i,
   input  wire logic               rx_line_i,
   input  wire ser_rx_pkg::presc_t prescaler_i,
   rx_link_if.front                lnk
);
   import ser_rx_pkg::*;

   logic   meta_r;
   logic   sync2_r;
   logic   sync3_r;
   logic   level_r;
   presc_t div_r;
   logic   tick_r;

   // line idles high, so the chain resets to one
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         meta_r  <= 1'b1;
         sync2_r <= 1'b1;
         sync3_r <= 1'b1;
         level_r <= 1'b1;
      end
      else
      begin
         meta_r  <= rx_line_i;
         sync2_r <= meta_r;
         sync3_r <= sync2_r;
         if (sync2_r == sync3_r)
            level_r <= sync3_r;
      end
   end

   // one tick per prescaler period: the sixteen-times oversampling rate
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end
      else if (prescaler_i == '0 || div_r >= prescaler_i - 12'h001)
      begin
         div_r  <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         div_r  <= div_r + 12'h001;
         tick_r <= 1'b0;
      end
   end

   assign lnk.tick = tick_r;
   assign lnk.line = level_r;

endmodule

// ===== core/async_serial_receiver.sv
// Purpose: receive path of the serial interface, shifter plus holding buffer
// Assumes: core reads input registers with a one-cycle load strobe and address
// Notes:   read data appears on input_data_o one clock after the strobe
`timescale 1ns/10ps
// Operation
// - NRZ frames: start, 8/9 data, stop
// - sample line at sixteen times bit rate
// - start is low after three high samples
// - start bit launches data acquisition
// - four frame formats supported
// - parity selectable even or odd
// - ninth bit readable at status bit 2
// - stop moves character to buffer, sets full
// - data read returns character, clears full
// - unread buffer: overrun set, buffer kept
// - shifter steps sixteen sample states per bit
// - three samples, majority value, noise flag
// - noise never aborts the character
// - nine steps plain, ten for longer formats
// - frame error on parity or stop failure
// - ten low bits give break request
// - buffer machine loads character and flags
// - format codes 00,01,10,11 as listed
// - parity control: 0 odd, 1 even
// - receive only while enable bit set
// - mask bits gate full, overrun, break
module async_serial_receiver
(
   input  wire logic               clock_i,
   input  wire logic               rst_i,
   input  wire logic               rx_line_i,
   input  wire logic               input_load_instruction_i,
   input  wire logic [7:0]         input_addr_i,
   input  wire ser_rx_pkg::fmt_t   frame_format_select_i,
   input  wire logic               parity_or_ninth_bit_i,
   input  wire logic               receive_enable_bit_i,
   input  wire logic               full_interrupt_mask_i,
   input  wire logic               overrun_interrupt_mask_i,
   input  wire logic               break_interrupt_mask_i,
   input  wire ser_rx_pkg::presc_t prescaler_i,
   output logic [7:0]              input_data_o,
   output logic                    full_irq_o,
   output logic                    overrun_irq_o,
   output logic                    break_irq_o
);
   import ser_rx_pkg::*;

   typedef enum logic [1:0] {s_idle, s_start, s_acq} shift_state_t;
   typedef enum logic {hb_empty, hb_full} hold_state_t;

   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction
   function automatic logic [3:0] last_step(input fmt_t fmt);
      last_step = (fmt == FMT_8N1) ? STEP_LAST_SHORT : STEP_LAST_LONG;
   endfunction
   rx_link_if lnk ();
   rx_front u_front (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .rx_line_i   (rx_line_i),
      .prescaler_i (prescaler_i),
      .lnk         (lnk)
   );

   shift_state_t state_r;
   logic [2:0]   hist_r;
   logic [3:0]   scnt_r;
   logic [3:0]   idx_r;
   logic [1:0]   samp_r;
   logic [8:0]   shift_r;
   logic         noise_acc_r;
   logic         frame_acc_r;
   logic [3:0]   low_run_r;
   logic         done_r;
   logic         brk_r;
   logic         bit_now;
   logic         noisy_now;
   logic         stop_pos;
   logic         par_bad;
   logic         frame_hit;
   logic [3:0]   run_nxt;
   // bit decision at the third centre sample
   always_comb
   begin
      bit_now   = maj3(samp_r[0], samp_r[1], lnk.line);
      noisy_now = !(samp_r[0] == samp_r[1] && samp_r[1] == lnk.line);
      stop_pos  = (idx_r == last_step(frame_format_select_i))
                  || (idx_r == STEP_EXTRA && frame_format_select_i == FMT_8N2);
      // even parity wants an even count of ones including the parity bit
      par_bad   = ((^{shift_r[7:0], bit_now}) == parity_or_ninth_bit_i);
      frame_hit = (stop_pos && !bit_now)
                  || (idx_r == STEP_EXTRA && frame_format_select_i == FMT_8P1 && par_bad);
      if (bit_now)
         run_nxt = 4'h0;
      else if (low_run_r == BREAK_BITS)
         run_nxt = low_run_r;
      else
         run_nxt = low_run_r + 4'h1;
   end

   // oversampling shifter, advanced only on the oversampling tick
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_r     <= s_idle;
         hist_r      <= 3'h0;
         scnt_r      <= 4'h0;
         idx_r       <= 4'h0;
         samp_r      <= 2'h0;
         shift_r     <= 9'h000;
         noise_acc_r <= 1'b0;
         frame_acc_r <= 1'b0;
         low_run_r   <= 4'h0;
         done_r      <= 1'b0;
         brk_r       <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         brk_r  <= 1'b0;
         if (!receive_enable_bit_i)
         begin
            state_r <= s_idle;
            hist_r  <= 3'h0;
         end
         else if (lnk.tick)
         begin
            unique case (state_r)
               s_idle:
               begin
                  hist_r <= {hist_r[1:0], lnk.line};
                  if (lnk.line)
                     low_run_r <= 4'h0;
                  if (hist_r == 3'h7 && !lnk.line)
                  begin
                     state_r     <= s_start;
                     scnt_r      <= 4'h1;
                     noise_acc_r <= 1'b0;
                     frame_acc_r <= 1'b0;
                     shift_r     <= 9'h000;
                  end
               end
               s_start, s_acq:
               begin
                  scnt_r <= scnt_r + 4'h1;
                  if (scnt_r == SAMP_A)
                     samp_r[0] <= lnk.line;
                  if (scnt_r == SAMP_B)
                     samp_r[1] <= lnk.line;
                  if (scnt_r == SAMP_C)
                  begin
                     // noise is only recorded, the character goes on
                     noise_acc_r <= noise_acc_r | noisy_now;
                     low_run_r   <= run_nxt;
                     if (run_nxt == BREAK_BITS && low_run_r != BREAK_BITS)
                        brk_r <= 1'b1;
                     if (state_r == s_start)
                     begin
                        // a high majority means a glitch, not a start bit
                        if (!bit_now)
                           state_r <= s_acq;
                        else
                           state_r <= s_idle;
                        idx_r  <= 4'h0;
                        hist_r <= 3'h0;
                     end
                     else
                     begin
                        idx_r       <= idx_r + 4'h1;
                        frame_acc_r <= frame_acc_r | frame_hit;
                        if (idx_r < STEP_EXTRA)
                           shift_r[idx_r[2:0]] <= bit_now;
                        if (idx_r == STEP_EXTRA && frame_format_select_i == FMT_9N1)
                           shift_r[8] <= bit_now;
                        if (idx_r == last_step(frame_format_select_i))
                        begin
                           // ends at stop centre so the next start is not missed
                           state_r <= s_idle;
                           hist_r  <= 3'h0;
                           done_r  <= 1'b1;
                        end
                     end
                  end
               end
            endcase
         end
      end
   end

   hold_state_t hb_state_r;
   logic [7:0]  data_r;
   logic        ninth_r;
   logic        noise_r;
   logic        frame_r;
   logic        overrun_r;
   logic        rd_data;
   logic        rd_stat;
   logic        load_ok;
   logic [7:0]  status_v;

   assign rd_data = input_load_instruction_i && input_addr_i == ADDR_DATA_IN;
   assign rd_stat = input_load_instruction_i && input_addr_i == ADDR_STATUS;
   // a read in the same cycle as completion frees the buffer for the new one
   assign load_ok = (hb_state_r == hb_empty) || rd_data;

   // holding buffer; done_r is a single-cycle pulse, so each character loads once
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         hb_state_r <= hb_empty;
         data_r     <= DATA_RESET;
         ninth_r    <= 1'b0;
         noise_r    <= 1'b0;
         frame_r    <= 1'b0;
      end
      else if (done_r && load_ok)
      begin
         data_r     <= shift_r[7:0];
         ninth_r    <= shift_r[8];
         noise_r    <= noise_acc_r;
         frame_r    <= frame_acc_r;
         hb_state_r <= hb_full;
      end
      else if (rd_data)
         hb_state_r <= hb_empty;
   end

   // overrun is sticky until a status read; a new overrun wins over that clear
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         overrun_r <= 1'b0;
      else if (done_r && !load_ok)
         overrun_r <= 1'b1;
      else if (rd_stat)
         overrun_r <= 1'b0;
   end

   always_comb
   begin
      status_v             = STATUS_RESET;
      status_v[ST_NOISE]   = noise_r;
      status_v[ST_FRAME]   = frame_r;
      status_v[ST_FULL]    = (hb_state_r == hb_full);
      status_v[ST_OVERRUN] = overrun_r;
      status_v[ST_NINTH]   = ninth_r;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         input_data_o <= 8'h00;
      else if (rd_data)
         input_data_o <= data_r;
      else if (rd_stat)
         input_data_o <= status_v;
      else if (input_load_instruction_i)
         input_data_o <= 8'h00;
   end

   // interrupt requests, one-cycle pulses
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         full_irq_o    <= 1'b0;
         overrun_irq_o <= 1'b0;
         break_irq_o   <= 1'b0;
      end
      else
      begin
         full_irq_o    <= done_r && load_ok && full_interrupt_mask_i;
         overrun_irq_o <= done_r && !load_ok && overrun_interrupt_mask_i;
         break_irq_o   <= brk_r && break_interrupt_mask_i;
      end
   end

   property p_start_detect;
      @(posedge clock_i) disable iff (rst_i)
      (receive_enable_bit_i && lnk.tick && state_r == s_idle && hist_r == 3'h7 && !lnk.line)
      |=> (state_r == s_start && scnt_r == 4'h1);
   endproperty
   a_start_detect: assert property (p_start_detect) else $error("start not taken");
   property p_disabled_idle;
      @(posedge clock_i) disable iff (rst_i)
      !receive_enable_bit_i |=> (state_r == s_idle && !done_r);
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("rx active while off");
   property p_noise_flag;
      @(posedge clock_i) disable iff (rst_i)
      (receive_enable_bit_i && lnk.tick && state_r == s_acq && scnt_r == SAMP_C && noisy_now)
      |=> noise_acc_r;
   endproperty
   a_noise_flag: assert property (p_noise_flag) else $error("noise not recorded");
   property p_last_step;
      @(posedge clock_i) disable iff (rst_i)
      (receive_enable_bit_i && lnk.tick && state_r == s_acq && scnt_r == SAMP_C
       && idx_r == last_step(frame_format_select_i))
      |=> (done_r && state_r == s_idle) ##1 !done_r;
   endproperty
   a_last_step: assert property (p_last_step) else $error("character end wrong");
   property p_load_full;
      @(posedge clock_i) disable iff (rst_i)
      (done_r && load_ok) |=> (hb_state_r == hb_full && data_r == $past(shift_r[7:0]));
   endproperty
   a_load_full: assert property (p_load_full) else $error("buffer not loaded");
   property p_read_clear;
      @(posedge clock_i) disable iff (rst_i)
      (rd_data && !done_r) |=> (hb_state_r == hb_empty && input_data_o == $past(data_r));
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not empty");
   property p_overrun_keep;
      @(posedge clock_i) disable iff (rst_i)
      (done_r && hb_state_r == hb_full && !rd_data) |=> (overrun_r && $stable(data_r));
   endproperty
   a_overrun_keep: assert property (p_overrun_keep) else $error("overrun mishandled");
   property p_break_irq;
      @(posedge clock_i) disable iff (rst_i)
      (brk_r && break_interrupt_mask_i) |=> break_irq_o ##1 !break_irq_o;
   endproperty
   a_break_irq: assert property (p_break_irq) else $error("break request lost");
   property p_full_mask;
      @(posedge clock_i) disable iff (rst_i)
      full_irq_o |-> ($past(full_interrupt_mask_i) && hb_state_r == hb_full);
   endproperty
   a_full_mask: assert property (p_full_mask) else $error("unmasked full request");
   property p_unmapped;
      @(posedge clock_i) disable iff (rst_i)
      (input_load_instruction_i && !rd_data && !rd_stat) |=> input_data_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

// ===== tb/serial_tx_model.sv
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: bit time is BIT_CLKS master clocks, set by the bench
// Notes:   line idles high; the glitch covers one oversampling tick mid-bit
`timescale 1ns/10ps
module serial_tx_model #(
   parameter int BIT_CLKS = 64
)(
   input  wire logic clock_i,
   output logic      line_o
);
   initial line_o = 1'b1;

   // bits leave from index 0 upward, so data goes lsb first after the start bit
   task automatic send(input logic [11:0] bits, input int n, input int glit);
      int b;
      int c;
      for (b = 0; b < n; b++)
      begin
         for (c = 0; c < BIT_CLKS; c++)
         begin
            @(posedge clock_i);
            #1;
            line_o = bits[b] ^ (b == glit && c >= BIT_CLKS/2+2 && c < BIT_CLKS/2+6);
         end
      end
      @(posedge clock_i);
      #1;
      line_o = 1'b1;
   endtask
endmodule

// ===== tb/async_serial_receiver_test.sv
// Purpose: self-checking bench of the serial receive path
// Assumes: prescaler fixed at PRESC, so one bit is 16*PRESC clocks
// Notes:   a small reference model tracks the buffer, flags and irq counts
`timescale 1ns/10ps
module async_serial_receiver_test;
   import ser_rx_pkg::*;
   localparam int PRESC = 4;
   logic        clock_i;
   logic        rst_i;
   logic        rx_line;
   logic        load;
   logic        ren;
   logic        par;
   logic        fmask;
   logic        omask;
   logic        bmask;
   logic [7:0]  addr;
   logic [7:0]  rdata;
   fmt_t        fmt;
   logic        full_irq;
   logic        ovr_irq;
   logic        brk_irq;
   logic [7:0]  e_data;
   logic        e_noise;
   logic        e_frame;
   logic        e_full_f;
   logic        e_ovr_f;
   logic        e_ninth;
   int          miscompares;
   int          comparisons;
   int          n_full;
   int          n_ovr;
   int          n_brk;
   int          e_full;
   int          e_ovr;
   int          e_brk;
   int unsigned seed;

   serial_tx_model #(.BIT_CLKS(OVERSAMPLE*PRESC)) tx (.clock_i(clock_i), .line_o(rx_line));

   async_serial_receiver DUT (
      .clock_i                  (clock_i),
      .rst_i                    (rst_i),
      .rx_line_i                (rx_line),
      .input_load_instruction_i (load),
      .input_addr_i             (addr),
      .frame_format_select_i    (fmt),
      .parity_or_ninth_bit_i    (par),
      .receive_enable_bit_i     (ren),
      .full_interrupt_mask_i    (fmask),
      .overrun_interrupt_mask_i (omask),
      .break_interrupt_mask_i   (bmask),
      .prescaler_i              (presc_t'(PRESC)),
      .input_data_o             (rdata),
      .full_irq_o               (full_irq),
      .overrun_irq_o            (ovr_irq),
      .break_irq_o              (brk_irq)
   );

   initial
   begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   always @(posedge clock_i)
   begin
      if (full_irq === 1'b1) n_full++;
      if (ovr_irq === 1'b1) n_ovr++;
      if (brk_irq === 1'b1) n_brk++;
   end

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // strobe for one cycle, answer is taken one clock after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      #1;
      load = 1'b1;
      addr = a;
      @(posedge clock_i);
      #1;
      load = 1'b0;
      d = rdata;
   endtask

   // status first so the full flag is still seen before the data read empties it
   task automatic read_regs();
      logic [7:0] d;
      logic [7:0] st;
      st = {e_noise, e_frame, e_full_f, e_ovr_f, 1'b0, e_ninth, 2'b00};
      rd(ADDR_STATUS, d);
      check(d, st, "status");
      e_ovr_f = 1'b0;
      rd(ADDR_DATA_IN, d);
      check(d, e_data, "data");
      e_full_f = 1'b0;
   endtask

   // bad: 1 inverts bit 9 (parity, first stop or ninth bit), 2 inverts the last stop
   task automatic frame(input logic [7:0] dat, input int bad, input int glit);
      logic [11:0] bits;
      int          n;
      logic        fe;
      repeat (OVERSAMPLE*PRESC) @(posedge clock_i);
      bits = {3'b111, dat, 1'b0};
      if (fmt == FMT_8P1) bits[9] = ^dat ^ ~par;
      if (fmt == FMT_9N1) bits[9] = 1'(rnd());
      n = (fmt == FMT_8N1) ? 10 : 11;
      if (bad == 1) bits[9] = ~bits[9];
      if (bad == 2) bits[n-1] = ~bits[n-1];
      fe = !bits[n-1] || (fmt == FMT_8N2 && !bits[9]) || (fmt == FMT_8P1 && (^bits[9:1]) == par);
      tx.send(bits, n, glit);
      if (ren)
      begin
         if (e_full_f)
         begin
            e_ovr_f = 1'b1;
            if (omask) e_ovr++;
         end
         else
         begin
            e_data = bits[8:1];
            e_noise = glit > 0;
            e_frame = fe;
            e_ninth = fmt == FMT_9N1 && bits[9];
            e_full_f = 1'b1;
            if (fmask) e_full++;
         end
      end
   endtask

   initial
   begin
      logic [7:0] d;
      logic [7:0] dat;
      int         i;
      seed = 94263;
      rst_i = 1'b1;
      load = 1'b0;
      addr = 8'h00;
      ren = 1'b1;
      par = 1'b0;
      fmt = FMT_8N1;
      {fmask, omask, bmask} = 3'b000;
      {e_data, e_noise, e_frame, e_full_f, e_ovr_f, e_ninth} = '0;
      {miscompares, comparisons, n_full, n_ovr, n_brk, e_full, e_ovr, e_brk} = '0;
      repeat (8) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      rd(8'h30, d);
      check(d, 8'h00, "unmapped");
      read_regs();
      for (i = 0; i < 16; i++)
      begin
         fmt = fmt_t'(i % 4);
         par = 1'(rnd());
         {fmask, omask, bmask} = 3'(rnd());
         dat = 8'(rnd());
         if (dat == 8'h00) dat = 8'h01;
         frame(dat, i % 3, (i % 5 == 1) ? 1 + i % 8 : -1);
         if (i % 6 != 5) read_regs();
      end
      // ten low bit decisions make a break and a zero character with a bad stop
      fmt = FMT_8N1;
      bmask = 1'b1;
      frame(8'h00, 2, -1);
      e_brk++;
      read_regs();
      ren = 1'b0;
      frame(8'ha5, 0, -1);
      ren = 1'b1;
      read_regs();
      check(8'(n_full), 8'(e_full), "full irqs");
      check(8'(n_ovr), 8'(e_ovr), "overrun irqs");
      check(8'(n_brk), 8'(e_brk), "break irqs");
      final_report();
   end

   initial
   begin
      repeat (60000) @(posedge clock_i);
      miscompares++;
      final_report();
   end
endmodule
